// *** ssc_switch_ctl.sv ***
// serial command interpreter and output control of a 16-channel switch
// assumes a host that keeps the serial clock low around select edges
`timescale 1ns/1ps
// How it works
// - serial output moves to next diagnostic bit on each clock rise
// - serial input sampled on clock fall, most significant bit first
// - frame is sixteen bits, control byte then active-high data byte
// - output tri-stated while deselected, driven msb first once selected
// - parallel channels take AND or OR of pin and serial bit
// - polarity pin high means active-high pins, low means active-low
// - unconnected parallel pins count as off inputs to the AND or OR
// - each channel latched; reset turns all outputs off
// - data bit high means on, low means off
// - select rise copies shifted bits into output control
// - answer word holds two diagnostic bits per group channel
// - control bits 0-3 low pick group one, high pick group two
// - nibble LLLL gives diagnosis, ignores data, keeps outputs
// - nibble HHLL returns parallel pins and one fault bit each
// - nibble HLHL loops serial input straight to serial output
// - nibble LLHH sets OR, applies data, full diagnosis
// - nibble HHHH sets AND, applies data, full diagnosis
// - undefined control word does nothing and clears shift register
// - diagnosis-only lasts one frame and never alters outputs
// - select fall loads diagnostic status into shift register
// - OR after reset; operation latched until other is programmed
// - codes HH ok, HL overload, LH open load, LL short ground
// - after readout the previously addressed group's faults clear
module ssc_switch_ctl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // serial pins
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // parallel inputs, channels 1-4 then 9-12; pin_open_ch1 and pin_open_ch9 low when wired
  input  wire logic [3:0]  parallel_input_ch1,
  input  wire logic [3:0]  parallel_input_ch9,
  input  wire logic [3:0]  pin_open_ch1,
  input  wire logic [3:0]  pin_open_ch9,
  input  wire logic        input_polarity_select,
  // per-channel fault codes from the power stage, two bits each
  input  wire logic [15:0] diag_word_low_group,
  input  wire logic [15:0] diag_word_high_group,
  // outputs
  output logic [15:0]      chan_on,
  output logic             mode_and_low,
  output logic             mode_and_high
);
  ssc_link_if lnk ();

  ssc_edge_det u_det (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sclk    (sclk),
    .sel_n   (sel_n),
    .sdi     (sdi),
    .lnk     (lnk)
  );

  // ***************************
  // pin synchronisers
  // ***************************
  logic [7:0]  par_s1;
  logic [7:0]  par_s2;
  logic [7:0]  opn_s1;
  logic [7:0]  opn_s2;
  logic [1:0]  pol_sy;
  logic [31:0] flt_s1;
  logic [31:0] flt_s2;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      par_s1 <= 8'h00;
      par_s2 <= 8'h00;
      opn_s1 <= 8'hFF;
      opn_s2 <= 8'hFF;
      pol_sy <= 2'h3;
      flt_s1 <= 32'hFFFFFFFF;
      flt_s2 <= 32'hFFFFFFFF;
    end else begin
      par_s1 <= {parallel_input_ch9, parallel_input_ch1};
      par_s2 <= par_s1;
      opn_s1 <= {pin_open_ch9, pin_open_ch1};
      opn_s2 <= opn_s1;
      pol_sy <= {pol_sy[0], input_polarity_select};
      flt_s1 <= {diag_word_high_group, diag_word_low_group};
      flt_s2 <= flt_s1;
    end
  end

  // ***************************
  // parallel input conditioning
  // ***************************
  logic [7:0] par_on;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_par
      // polarity per pin, open pin forces off
      assign par_on[gi] = ~opn_s2[gi] & (par_s2[gi] ~^ pol_sy[1]);
    end
  endgenerate

  // ***************************
  // shift registers
  // ***************************
  logic [15:0]        rx_shift;
  logic [15:0]        tx_shift;
  logic [ssc_pkg::CNT_W-1:0] bit_cnt;
  logic               echo_bit;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift <= ssc_pkg::RST_SHIFT;
      bit_cnt  <= '0;
      echo_bit <= 1'b0;
    end else if (lnk.sel_fall) begin
      bit_cnt <= '0;
    end else if (lnk.sclk_fall) begin
      rx_shift <= {rx_shift[14:0], lnk.si_bit};
      echo_bit <= lnk.si_bit;
      if (bit_cnt != ssc_pkg::CNT_W'(ssc_pkg::FRAME_BITS))
        bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // ***************************
  // command decode
  // ***************************
  logic [3:0] cmd_hi;
  logic [3:0] cmd_grp;
  logic       grp_ok;
  logic       grp_high;
  logic       cmd_valid;
  logic       frame_ok;

  assign cmd_hi   = rx_shift[15:12];
  assign cmd_grp  = rx_shift[11:8];
  assign grp_ok   = (cmd_grp == ssc_pkg::GRP_LOW) |
                    (cmd_grp == ssc_pkg::GRP_HIGH);
  assign grp_high = (cmd_grp == ssc_pkg::GRP_HIGH);
  assign cmd_valid = grp_ok & ((cmd_hi == ssc_pkg::CMD_DIAG) |
                     (cmd_hi == ssc_pkg::CMD_READ) |
                     (cmd_hi == ssc_pkg::CMD_ECHO) |
                     (cmd_hi == ssc_pkg::CMD_OR) |
                     (cmd_hi == ssc_pkg::CMD_AND));
  // a short frame is treated like an undefined word; a long one keeps its last 16 bits
  assign frame_ok = cmd_valid &
                    (bit_cnt == ssc_pkg::CNT_W'(ssc_pkg::FRAME_BITS));

  // ***************************
  // output latches per group
  // ***************************
  logic [7:0] ser_low;
  logic [7:0] ser_high;
  logic       apply;

  // only OR and AND apply data
  assign apply = lnk.sel_rise & frame_ok &
                 ((cmd_hi == ssc_pkg::CMD_OR) | (cmd_hi == ssc_pkg::CMD_AND));

  // copy data on select rise, reset clears
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_low  <= ssc_pkg::RST_CHAN;
      ser_high <= ssc_pkg::RST_CHAN;
    end else if (apply) begin
      if (grp_high)
        ser_high <= rx_shift[7:0];
      else
        ser_low  <= rx_shift[7:0];
    end
  end

  // OR after reset, latched per group
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_and_low  <= 1'b0;
      mode_and_high <= 1'b0;
    end else if (apply) begin
      if (grp_high)
        mode_and_high <= (cmd_hi == ssc_pkg::CMD_AND);
      else
        mode_and_low  <= (cmd_hi == ssc_pkg::CMD_AND);
    end
  end

  // ***************************
  // output combining
  // ***************************
  logic [15:0] next_chan_on;

  always_comb begin
    next_chan_on = {ser_high, ser_low};
    for (int i = 0; i < 4; i++) begin
      next_chan_on[i]   = mode_and_low ? (ser_low[i] & par_on[i])
                                       : (ser_low[i] | par_on[i]);
      next_chan_on[8+i] = mode_and_high ? (ser_high[i] & par_on[4+i])
                                        : (ser_high[i] | par_on[4+i]);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      chan_on <= 16'h0000;
    else
      chan_on <= next_chan_on;
  end

  // ***************************
  // readback request for next frame
  // ***************************
  ssc_pkg::ssc_rb_t rb_kind;
  logic             rb_high;
  logic             rb_read;

  // answer kind chosen at frame end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rb_kind <= ssc_pkg::SSC_RB_ZERO;
      rb_high <= 1'b0;
      rb_read <= 1'b0;
    end else if (lnk.sel_rise) begin
      rb_high <= grp_high;
      rb_read <= (cmd_hi == ssc_pkg::CMD_READ);
      if (!frame_ok)
        rb_kind <= ssc_pkg::SSC_RB_ZERO;
      else if (cmd_hi == ssc_pkg::CMD_ECHO)
        rb_kind <= ssc_pkg::SSC_RB_ECHO;
      else
        rb_kind <= ssc_pkg::SSC_RB_DIAG;
    end
  end

  // ***************************
  // diagnosis registers
  // ***************************
  logic [15:0] diag_low;
  logic [15:0] diag_high;
  logic [15:0] diag_sel;
  logic [7:0]  flt_bit;
  logic        clr_low;
  logic        clr_high;

  // clear group read out by the previous command
  assign clr_low  = lnk.sel_fall & (rb_kind == ssc_pkg::SSC_RB_DIAG) &
                    ~rb_high;
  assign clr_high = lnk.sel_fall & (rb_kind == ssc_pkg::SSC_RB_DIAG) &
                    rb_high;

  // faults are sticky (low bits); a fresh fault wins over the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_low  <= 16'hFFFF;
      diag_high <= 16'hFFFF;
    end else begin
      diag_low  <= (clr_low ? 16'hFFFF : diag_low) & flt_s2[15:0];
      diag_high <= (clr_high ? 16'hFFFF : diag_high) & flt_s2[31:16];
    end
  end

  assign diag_sel = rb_high ? diag_high : diag_low;

  // one-bit fault: low unless code is HH
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flt
      assign flt_bit[gi] = (diag_sel[2*gi+1 -: 2] == ssc_pkg::DIAG_OK);
    end
  endgenerate

  // ***************************
  // serial output
  // ***************************
  logic [15:0] next_load;

  always_comb begin
    next_load = ssc_pkg::RST_SHIFT;
    unique case (rb_kind)
      ssc_pkg::SSC_RB_ZERO: next_load = ssc_pkg::RST_SHIFT;
      ssc_pkg::SSC_RB_ECHO: next_load = ssc_pkg::RST_SHIFT;
      ssc_pkg::SSC_RB_DIAG: next_load = rb_read ?
        {rb_high ? {4'h0, par_on[7:4]} : {4'h0, par_on[3:0]}, flt_bit} :
        diag_sel;
      default: next_load = ssc_pkg::RST_SHIFT;
    endcase
  end

  // load on select fall, shift on clock rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      tx_shift <= ssc_pkg::RST_SHIFT;
    else if (lnk.sel_fall)
      tx_shift <= next_load;
    else if (lnk.sclk_rise)
      tx_shift <= {tx_shift[14:0], 1'b0};
  end

  // drive only while selected, echo loop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= lnk.sel_active;
      if (rb_kind == ssc_pkg::SSC_RB_ECHO)
        sdo <= lnk.sel_fall ? 1'b0 : echo_bit;
      else if (lnk.sel_fall)
        sdo <= next_load[15];
      else if (lnk.sclk_rise)
        sdo <= tx_shift[14];
    end
  end

  // ***************************
  // checks
  // ***************************
  sequence s_bad_frame_end;
    lnk.sel_rise && !frame_ok;
  endsequence

  AST_OE_FOLLOWS_SEL: assert property (@(posedge clk) disable iff (sys_rst)
    lnk.sel_fall |=> sdo_oe)
    else $error("output not enabled after select fall");
  AST_OE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    lnk.sel_rise |=> !sdo_oe)
    else $error("output still enabled after deselect");
  AST_BAD_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    s_bad_frame_end |=> rb_kind == ssc_pkg::SSC_RB_ZERO)
    else $error("undefined word did not zero the answer");
  AST_BAD_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
    s_bad_frame_end |=> $stable(ser_low) && $stable(ser_high))
    else $error("undefined word changed outputs");
  AST_DIAG_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
    lnk.sel_rise && cmd_hi == ssc_pkg::CMD_DIAG
    |=> $stable(ser_low) && $stable(ser_high))
    else $error("diagnosis frame changed outputs");
  AST_APPLY_DATA: assert property (@(posedge clk) disable iff (sys_rst)
    apply && !grp_high |=> ser_low == $past(rx_shift[7:0]))
    else $error("data byte not copied on select rise");
  AST_AND_MODE: assert property (@(posedge clk) disable iff (sys_rst)
    apply && cmd_hi == ssc_pkg::CMD_AND && grp_high
    |=> mode_and_high)
    else $error("and mode not latched");
  AST_OR_MODE: assert property (@(posedge clk) disable iff (sys_rst)
    apply && cmd_hi == ssc_pkg::CMD_OR && !grp_high
    |=> !mode_and_low)
    else $error("or mode not latched");
  AST_AND_GATES: assert property (@(posedge clk) disable iff (sys_rst)
    mode_and_high && !par_on[6] |=> !chan_on[10])
    else $error("and mode let channel on without pin");
  AST_SHIFT_OUT: assert property (@(posedge clk) disable iff (sys_rst)
    lnk.sclk_rise && rb_kind != ssc_pkg::SSC_RB_ECHO && !lnk.sel_fall
    |=> sdo == $past(tx_shift[14]))
    else $error("serial output did not advance");
endmodule : ssc_switch_ctl

// *** ssc_pkg.sv ***
// package of constants for the spi switch channel control block
// assumes a 200 MHz system clock sampling a slow serial link
package ssc_pkg;
  // ***************************
  // frame layout
  // ***************************
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W      = 5;
  localparam logic [3:0]  GRP_LOW    = 4'h0;
  localparam logic [3:0]  GRP_HIGH   = 4'hF;
  // ***************************
  // upper nibble command codes
  // ***************************
  localparam logic [3:0]  CMD_DIAG   = 4'h0;
  localparam logic [3:0]  CMD_READ   = 4'hC;
  localparam logic [3:0]  CMD_ECHO   = 4'hA;
  localparam logic [3:0]  CMD_OR     = 4'h3;
  localparam logic [3:0]  CMD_AND    = 4'hF;
  // ***************************
  // diagnostic codes per channel
  // ***************************
  localparam logic [1:0]  DIAG_OK    = 2'h3;
  localparam logic [1:0]  DIAG_OVL   = 2'h2;
  localparam logic [1:0]  DIAG_OPEN  = 2'h1;
  localparam logic [1:0]  DIAG_SHG   = 2'h0;
  // ***************************
  // reset values
  // ***************************
  localparam logic [15:0] RST_SHIFT  = 16'h0000;
  localparam logic [7:0]  RST_CHAN   = 8'h00;
  localparam logic [1:0]  RST_SYNC   = 2'h0;

  typedef enum logic [2:0] {
    SSC_RB_ZERO = 3'b001,
    SSC_RB_DIAG = 3'b010,
    SSC_RB_ECHO = 3'b100
  } ssc_rb_t;
endpackage : ssc_pkg

// *** ssc_link_if.sv ***
// carrier between the top and its serial edge detector
// assumes one clock domain; the pins are synchronised before use
`timescale 1ns/1ps
interface ssc_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic sel_active;
  logic si_bit;
  modport det (output sclk_rise, sclk_fall, sel_fall, sel_rise,
               sel_active, si_bit);
  modport core (input sclk_rise, sclk_fall, sel_fall, sel_rise,
                sel_active, si_bit);
endinterface : ssc_link_if

// *** ssc_edge_det.sv ***
// two-flop synchronisers and edge finders for the serial pins
// assumes pins come from outside the clk domain
`timescale 1ns/1ps
module ssc_edge_det (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pins
  input  wire logic sclk,
  input  wire logic sel_n,
  input  wire logic sdi,
  // events
  ssc_link_if.det   lnk
);
  logic [1:0] sclk_sy;
  logic [1:0] sel_sy;
  logic [1:0] sdi_sy;
  logic       sclk_q;
  logic       sel_q;

  // ***************************
  // synchronisers
  // ***************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_sy <= ssc_pkg::RST_SYNC;
      sel_sy  <= 2'h3;
      sdi_sy  <= ssc_pkg::RST_SYNC;
      sclk_q  <= 1'b0;
      sel_q   <= 1'b1;
    end else begin
      sclk_sy <= {sclk_sy[0], sclk};
      sel_sy  <= {sel_sy[0], sel_n};
      sdi_sy  <= {sdi_sy[0], sdi};
      sclk_q  <= sclk_sy[1];
      sel_q   <= sel_sy[1];
    end
  end

  // clock edges only count while selected, so idle toggling is ignored
  assign lnk.sclk_rise  = sclk_sy[1] & ~sclk_q & ~sel_sy[1];
  assign lnk.sclk_fall  = ~sclk_sy[1] & sclk_q & ~sel_sy[1];
  assign lnk.sel_fall   = ~sel_sy[1] & sel_q;
  assign lnk.sel_rise   = sel_sy[1] & ~sel_q;
  assign lnk.sel_active = ~sel_sy[1];
  assign lnk.si_bit     = sdi_sy[1];
endmodule : ssc_edge_det

// *** ssc_host_model.sv ***
// behavioural host driving the serial pins of the switch controller
// assumes the 200 MHz clk of the bench; link clock is 80 ns per bit
`timescale 1ns/1ps
module ssc_host_model (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      sel_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // half of the 80 ns link period in clk cycles
  localparam int HALF = 8;
  int oe_bad;

  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
    oe_bad = 0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // ***************************
  // one frame; sdo taken just before each rise, where a bit stands
  // ***************************
  task automatic xfer(input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(posedge clk);
    sel_n <= 1'b0;
    wait_clk(HALF * 5);
    for (i = 15; i > 15 - nbits; i--) begin
      rx[i] = sdo;
      if (sdo_oe !== 1'b1) oe_bad++;
      // data moves on the rise so it holds well past the fall
      sclk <= 1'b1;
      sdi <= tx[i];
      wait_clk(HALF);
      sclk <= 1'b0;
      wait_clk(HALF);
    end
    wait_clk(HALF * 3);
    sel_n <= 1'b1;
    // released line settles at its pull-down level
    sdi <= 1'b0;
    wait_clk(HALF * 5);
  endtask : xfer
endmodule : ssc_host_model

// *** spi_switch_channel_control_bench.sv ***
// self-checking bench for the switch controller with a host model
// assumes the answer of a frame arrives during the following frame
`timescale 1ns/1ps
module spi_switch_channel_control_bench;
  localparam logic [15:0] DIAG_LOW  = 16'h1BE4;
  localparam logic [15:0] DIAG_HIGH = 16'h9C63;
  localparam int          LIMIT     = 12000;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sclk, sel_n, sdi, sdo, sdo_oe;
  logic [3:0]  parallel_input_ch1 = 4'h3;
  logic [3:0]  parallel_input_ch9 = 4'h0;
  logic [3:0]  pin_open_ch1 = 4'h0;
  logic [3:0]  pin_open_ch9 = 4'h0;
  logic        input_polarity_select = 1'b1;
  logic [15:0] diag_word_low_group = DIAG_LOW;
  logic [15:0] diag_word_high_group = DIAG_HIGH;
  logic [15:0] chan_on;
  logic        mode_and_low, mode_and_high;
  logic [15:0] rx;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #2.5 clk = ~clk;

  ssc_switch_ctl ssc_switch_ctl_i (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .sel_n(sel_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .parallel_input_ch1(parallel_input_ch1),
    .parallel_input_ch9(parallel_input_ch9),
    .pin_open_ch1(pin_open_ch1), .pin_open_ch9(pin_open_ch9),
    .input_polarity_select(input_polarity_select),
    .diag_word_low_group(diag_word_low_group),
    .diag_word_high_group(diag_word_high_group),
    .chan_on(chan_on), .mode_and_low(mode_and_low),
    .mode_and_high(mode_and_high));

  ssc_host_model ssc_host_model_i (
    .clk(clk), .sclk(sclk), .sel_n(sel_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));

  // ***************************
  // compare and report
  // ***************************
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check16

  task automatic check1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check1

  task automatic stop_test;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  task automatic frame(input logic [15:0] tx);
    ssc_host_model_i.xfer(tx, 16, rx);
  endtask : frame

  // ***************************
  // scenarios
  // ***************************
  task automatic test_reset;
    // OR default lets the two active parallel pins through after reset
    check16(chan_on, 16'h0003);
    check1(mode_and_low, 1'b0);
    check1(mode_and_high, 1'b0);
    check1(sdo_oe, 1'b0);
  endtask : test_reset

  task automatic test_or_low;
    frame(16'h30A5);
    check16({8'h00, chan_on[7:0]}, 16'h00A7);
    check1(mode_and_low, 1'b0);
    check1(sdo_oe, 1'b0);
  endtask : test_or_low

  task automatic test_diag_low;
    frame(16'h00FF);
    check16(rx, DIAG_LOW);
    check16({8'h00, chan_on[7:0]}, 16'h00A7);
    frame(16'h0000);
    check16(rx, DIAG_LOW);
    check16({8'h00, chan_on[7:0]}, 16'h00A7);
  endtask : test_diag_low

  task automatic test_and_high;
    @(posedge clk);
    input_polarity_select <= 1'b0;
    pin_open_ch9 <= 4'h4;
    frame(16'hFF3C);
    check16({8'h00, chan_on[15:8]}, 16'h0038);
    check1(mode_and_high, 1'b1);
    check1(mode_and_low, 1'b0);
    frame(16'h0F00);
    check16(rx, DIAG_HIGH);
    check16({8'h00, chan_on[15:8]}, 16'h0038);
    check1(mode_and_high, 1'b1);
    @(posedge clk);
    input_polarity_select <= 1'b1;
    pin_open_ch9 <= 4'h0;
  endtask : test_and_high

  task automatic test_readback;
    frame(16'hC000);
    frame(16'h70FF);
    check16(rx, 16'h0318);
    check16({8'h00, chan_on[7:0]}, 16'h00A7);
    frame(16'h0000);
    check16(rx, 16'h0000);
  endtask : test_readback

  task automatic test_echo;
    frame(16'hA000);
    frame(16'h5A3C);
    // first bit goes out before any bit is sampled
    check16(rx & 16'h7FFF, 16'h2D1E);
    frame(16'h0000);
    check16(rx, 16'h0000);
  endtask : test_echo

  task automatic test_short;
    ssc_host_model_i.xfer(16'h3000, 15, rx);
    check16({8'h00, chan_on[7:0]}, 16'h00A7);
    frame(16'h0000);
    check16(rx, 16'h0000);
  endtask : test_short

  task automatic test_reset_mid;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    check16(chan_on, 16'h0000);
    check1(mode_and_high, 1'b0);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check16(chan_on, 16'h0003);
    check1(mode_and_high, 1'b0);
  endtask : test_reset_mid

  task automatic test_diag_clear;
    @(posedge clk);
    diag_word_low_group <= {8{ssc_pkg::DIAG_OK}};
    frame(16'h0000);
    check16(rx, DIAG_LOW);
    frame(16'h0000);
    check16(rx, {8{ssc_pkg::DIAG_OK}});
    @(posedge clk);
    diag_word_low_group <= DIAG_LOW;
  endtask : test_diag_clear

  initial begin
    repeat (6) @(posedge clk);
    check16(chan_on, 16'h0000);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    test_reset();
    test_or_low();
    test_diag_low();
    test_and_high();
    test_readback();
    test_echo();
    test_short();
    test_diag_clear();
    test_reset_mid();
    check16(16'(ssc_host_model_i.oe_bad), 16'h0000);
    stop_test();
  end
endmodule : spi_switch_channel_control_bench
